/* File: logic/nsb_consts.vh */
// Constants for the normal-space bus interface
// Summary of operation
// - Latch endian pin at reset: low big
// - Support 8, 16 and 32 bit buses
// - Split wide accesses into narrower bus accesses
// - 32-bit big endian: offset 0 on top
// - 16-bit big endian: even bytes upper lane
// - 8-bit big endian: MSB first, lane 0
// - 32-bit little endian: offset 0 on bottom
// - 16-bit little endian: low half first
// - 8-bit little endian: LSB first, lane 0
// - Alignment and width conversion are automatic
// - No-wait access takes exactly two cycles
// - Bus-start strobe one cycle per bus cycle
// - Reads full width; writes strobe written bytes
// - Direction output reads high when idle
// - Mask 0: idle cycle, honour wait input
// - Independent read and write software waits
// - Sample wait at falling edge before final cycle
// - Programmable select lead and trail cycles
// - Strobes negated in lead and trail cycles
// - Write data held through trail cycles
`ifndef NSB_CONSTS_VH
`define NSB_CONSTS_VH
`define NSB_BW_8         2'b01
`define NSB_BW_16        2'b10
`define NSB_BW_32        2'b11
`define NSB_SZ_BYTE      2'b00
`define NSB_SZ_WORD      2'b01
`define NSB_SZ_LONG      2'b10
`define NSB_ST_IDLE      8'h01
`define NSB_ST_LEAD      8'h02
`define NSB_ST_FIRST     8'h04
`define NSB_ST_WAIT      8'h08
`define NSB_ST_FINAL     8'h10
`define NSB_ST_TRAIL     8'h20
`define NSB_ST_NOP       8'h40
`define NSB_ST_DONE      8'h80
`define NSB_CKO_DIV      4'd8
`endif

/* File: logic/nsb_lane_map.v */
// Byte lane steering and strobe selection for one bus access
`timescale 1ns/100ps
`include "nsb_consts.vh"
module nsb_lane_map (
    // Configuration
    input  wire        big_endian_i,
    input  wire [1:0]  bus_width_i,
    input  wire [1:0]  size_i,
    // Access pieces
    input  wire [1:0]  addr_i,
    input  wire [1:0]  piece_i,
    input  wire [31:0] wdata_i,
    // Lane results
    output reg  [1:0]  bus_addr_o,
    output reg  [31:0] lane_data_o,
    output reg  [3:0]  lane_en_o,
    output reg  [1:0]  src_byte_o
);
    // Piece byte index within the internal value, plus lane choice
    reg [1:0] nbytes_m1;
    reg [1:0] off;
    reg [1:0] rel;
    reg [7:0] bval;
    always @* begin
        nbytes_m1   = (size_i == `NSB_SZ_LONG) ? 2'd3 :
                      (size_i == `NSB_SZ_WORD) ? 2'd1 : 2'd0;
        lane_data_o = 32'h0000_0000;
        lane_en_o   = 4'h0;
        bus_addr_o  = addr_i;
        src_byte_o  = 2'd0;
        off         = addr_i;
        rel         = 2'd0;
        bval        = 8'h00;
        case (bus_width_i)
        `NSB_BW_8: begin
            off        = addr_i + piece_i;
            bus_addr_o = off;
            rel        = piece_i;
            // Big endian sends the top byte first
            src_byte_o = big_endian_i ? (nbytes_m1 - rel)
                                      : rel;
            bval       = wdata_i[8*src_byte_o +: 8];
            lane_data_o = {24'h000000, bval};
            lane_en_o   = 4'h1;
        end
        `NSB_BW_16: begin
            bus_addr_o = addr_i + {piece_i[0], 1'b0};
            if (size_i == `NSB_SZ_BYTE) begin
                lane_en_o = (addr_i[0] ^ big_endian_i) ? 4'h2 : 4'h1;
                lane_data_o = {16'h0000, wdata_i[7:0], wdata_i[7:0]};
            end else begin
                lane_en_o = 4'h3;
                if (size_i == `NSB_SZ_LONG &&
                    (piece_i[0] ^ big_endian_i))
                    lane_data_o = {16'h0000, wdata_i[31:16]};
                else
                    lane_data_o = {16'h0000, wdata_i[15:0]};
            end
        end
        default: begin
            // 32-bit lanes, both endians
            case (size_i)
            `NSB_SZ_BYTE: begin
                off = big_endian_i ? ~addr_i : addr_i;
                lane_en_o   = 4'h1 << off;
                lane_data_o = {4{wdata_i[7:0]}};
            end
            `NSB_SZ_WORD: begin
                lane_en_o = (addr_i[1] ^ big_endian_i) ? 4'hc : 4'h3;
                lane_data_o = {2{wdata_i[15:0]}};
            end
            default: begin
                lane_en_o   = 4'hf;
                lane_data_o = wdata_i;
            end
            endcase
        end
        endcase
    end
endmodule

/* File: logic/nsb_bus_if.v */
// Normal-space external bus sequencer with lane steering
`timescale 1ns/100ps
`include "nsb_consts.vh"
module nsb_bus_if #(
    parameter CKO_DIV = 8
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // Straps and configuration
    input  wire        endian_select_pin_i,
    input  wire [1:0]  bus_width_i,
    input  wire [3:0]  read_wait_count_i,
    input  wire [2:0]  write_wait_count_i,
    input  wire        external_wait_mask_i,
    input  wire [1:0]  select_lead_cycles_i,
    input  wire [1:0]  select_trail_cycles_i,
    // Internal request
    input  wire        req_valid_i,
    input  wire        req_write_i,
    input  wire [1:0]  req_size_i,
    input  wire [31:0] req_addr_i,
    input  wire [31:0] req_wdata_i,
    output wire        req_ready_o,
    output reg         rsp_valid_o,
    output reg  [31:0] rsp_rdata_o,
    output wire        big_endian_o,
    // External bus pins
    output reg         bus_clock_output_o,
    output reg  [31:0] addr_o,
    output reg  [31:0] data_o,
    output reg         data_oen_o,
    input  wire [31:0] data_i,
    output reg         area_chip_select_n_o,
    output reg         bus_start_strobe_n_o,
    output reg         read_strobe_n_o,
    output reg  [3:0]  byte_write_strobe_n_o,
    output reg         read_write_direction_o,
    input  wire        ext_wait_n_i
);
    ////////////////////////////////////////////////////////////////////
    // Bus clock divider: one cycle of the bus is CKO_DIV clk cycles
    reg [3:0] div_ff;
    wire      bus_tick = (div_ff == CKO_DIV[3:0] - 4'd1);
    wire      fall_tick = (div_ff == CKO_DIV[3:0]/4'd2 - 4'd1);
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_ff             <= 4'd0;
            bus_clock_output_o <= 1'b1;
        end else begin
            div_ff <= bus_tick ? 4'd0 : div_ff + 4'd1;
            if (bus_tick)
                bus_clock_output_o <= 1'b1;
            else if (fall_tick)
                bus_clock_output_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Endian strap caught on the first bus tick after reset release with two steady sync stages
    reg endian_done_ff;
    reg little_ff;
    reg [2:0] strap_sync_ff;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            endian_done_ff <= 1'b0;
            little_ff      <= 1'b0;
            strap_sync_ff  <= 3'b000;
        end else begin
            strap_sync_ff <= {strap_sync_ff[1:0], endian_select_pin_i};
            // Wait until the sync chain is filled before latching
            if (!endian_done_ff && strap_sync_ff[2] == strap_sync_ff[1]
                && bus_tick) begin
                little_ff      <= strap_sync_ff[2];
                endian_done_ff <= 1'b1;
            end
        end
    end
    assign big_endian_o = ~little_ff;

    ////////////////////////////////////////////////////////////////////
    // External wait input synchroniser, three stages
    reg [2:0] wait_sync_ff;
    reg       wait_n_ff;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_sync_ff <= 3'b111;
            wait_n_ff    <= 1'b1;
        end else begin
            wait_sync_ff <= {wait_sync_ff[1:0], ext_wait_n_i};
            if (wait_sync_ff[2] == wait_sync_ff[1])
                wait_n_ff <= wait_sync_ff[2];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Captured request and per-piece lane mapping
    reg        wr_ff;
    reg [1:0]  size_ff;
    reg [31:0] addr_ff;
    reg [31:0] wdata_ff;
    reg [1:0]  bw_ff;
    reg [1:0]  piece_ff;
    reg [1:0]  last_piece_ff;
    wire [1:0]  map_addr;
    wire [31:0] map_data;
    wire [3:0]  map_en;
    wire [1:0]  map_src;

    nsb_lane_map u_map (
        .big_endian_i (~little_ff),
        .bus_width_i  (bw_ff),
        .size_i       (size_ff),
        .addr_i       (addr_ff[1:0]),
        .piece_i      (piece_ff),
        .wdata_i      (wdata_ff),
        .bus_addr_o   (map_addr),
        .lane_data_o  (map_data),
        .lane_en_o    (map_en),
        .src_byte_o   (map_src)
    );

    // Number of pieces minus one for the chosen bus width
    reg [1:0] pieces_m1;
    always @* begin
        pieces_m1 = 2'd0;
        if (bus_width_i == `NSB_BW_8)
            pieces_m1 = (req_size_i == `NSB_SZ_LONG) ? 2'd3 :
                        (req_size_i == `NSB_SZ_WORD) ? 2'd1 : 2'd0;
        else if (bus_width_i == `NSB_BW_16)
            pieces_m1 = (req_size_i == `NSB_SZ_LONG) ? 2'd1 : 2'd0;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus cycle state machine, advanced on bus clock rising ticks
    reg [7:0] state_ff;
    reg [3:0] cnt_ff;
    reg       more_wait_ff;
    wire      idle = state_ff[0];
    assign req_ready_o = idle & endian_done_ff & bus_tick;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff      <= `NSB_ST_IDLE;
            cnt_ff        <= 4'd0;
            wr_ff         <= 1'b0;
            size_ff       <= `NSB_SZ_BYTE;
            addr_ff       <= 32'h0000_0000;
            wdata_ff      <= 32'h0000_0000;
            bw_ff         <= `NSB_BW_32;
            piece_ff      <= 2'd0;
            last_piece_ff <= 2'd0;
            more_wait_ff  <= 1'b0;
            rsp_valid_o   <= 1'b0;
            rsp_rdata_o   <= 32'h0000_0000;
        end else begin
            rsp_valid_o <= 1'b0;
            // Wait pin read at the falling edge before the final cycle
            if (fall_tick)
                more_wait_ff <= ~external_wait_mask_i & ~wait_n_ff;
            if (bus_tick) begin
                case (state_ff)
                `NSB_ST_IDLE: begin
                    if (req_valid_i && endian_done_ff) begin
                        wr_ff         <= req_write_i;
                        size_ff       <= req_size_i;
                        addr_ff       <= req_addr_i;
                        wdata_ff      <= req_wdata_i;
                        bw_ff         <= bus_width_i;
                        piece_ff      <= 2'd0;
                        last_piece_ff <= pieces_m1;
                        rsp_rdata_o   <= 32'h0000_0000;
                        cnt_ff        <= {2'b00, select_lead_cycles_i};
                        state_ff      <= (select_lead_cycles_i != 2'd0) ?
                                         `NSB_ST_LEAD : `NSB_ST_FIRST;
                    end
                end
                `NSB_ST_LEAD: begin
                    cnt_ff <= cnt_ff - 4'd1;
                    if (cnt_ff == 4'd1)
                        state_ff <= `NSB_ST_FIRST;
                end
                `NSB_ST_FIRST: begin
                    // Software wait count chosen by direction
                    cnt_ff <= wr_ff ? {1'b0, write_wait_count_i}
                                    : read_wait_count_i;
                    if ((wr_ff ? {1'b0, write_wait_count_i}
                               : read_wait_count_i) != 4'd0 || more_wait_ff)
                        state_ff <= `NSB_ST_WAIT;
                    else
                        state_ff <= `NSB_ST_FINAL;
                end
                `NSB_ST_WAIT: begin
                    if (cnt_ff != 4'd0)
                        cnt_ff <= cnt_ff - 4'd1;
                    if (cnt_ff <= 4'd1 && !more_wait_ff)
                        state_ff <= `NSB_ST_FINAL;
                end
                `NSB_ST_FINAL: begin
                    // Read captures only the lanes that the access uses
                    if (!wr_ff) begin
                        case (bw_ff)
                        `NSB_BW_8:
                            rsp_rdata_o[8*map_src +: 8] <= data_i[7:0];
                        `NSB_BW_16:
                            if (size_ff == `NSB_SZ_LONG &&
                                (piece_ff[0] ^ ~little_ff))
                                rsp_rdata_o[31:16] <= data_i[15:0];
                            else if (size_ff == `NSB_SZ_BYTE)
                                rsp_rdata_o[7:0] <= map_en[1] ?
                                    data_i[15:8] : data_i[7:0];
                            else
                                rsp_rdata_o[15:0] <= data_i[15:0];
                        default:
                            rsp_rdata_o <= (size_ff == `NSB_SZ_BYTE) ?
                                {24'h000000, map_en[3] ? data_i[31:24] :
                                 map_en[2] ? data_i[23:16] :
                                 map_en[1] ? data_i[15:8] : data_i[7:0]} :
                                (size_ff == `NSB_SZ_WORD) ?
                                {16'h0000, map_en[3] ? data_i[31:16] :
                                 data_i[15:0]} : data_i;
                        endcase
                    end
                    cnt_ff   <= {2'b00, select_trail_cycles_i};
                    state_ff <= (select_trail_cycles_i != 2'd0) ?
                                `NSB_ST_TRAIL : `NSB_ST_DONE;
                end
                `NSB_ST_TRAIL: begin
                    cnt_ff <= cnt_ff - 4'd1;
                    if (cnt_ff == 4'd1)
                        state_ff <= `NSB_ST_DONE;
                end
                `NSB_ST_DONE: begin
                    if (piece_ff != last_piece_ff) begin
                        piece_ff <= piece_ff + 2'd1;
                        cnt_ff   <= {2'b00, select_lead_cycles_i};
                        state_ff <= external_wait_mask_i ?
                            ((select_lead_cycles_i != 2'd0) ?
                             `NSB_ST_LEAD : `NSB_ST_FIRST) : `NSB_ST_NOP;
                    end else begin
                        rsp_valid_o <= 1'b1;
                        piece_ff    <= 2'd0;
                        state_ff    <= external_wait_mask_i ?
                                       `NSB_ST_IDLE : `NSB_ST_NOP;
                    end
                end
                `NSB_ST_NOP: begin
                    // Idle evaluation cycle; piece 0 means access finished
                    if (piece_ff == 2'd0)
                        state_ff <= `NSB_ST_IDLE;
                    else
                        state_ff <= (cnt_ff != 4'd0) ?
                                    `NSB_ST_LEAD : `NSB_ST_FIRST;
                end
                default: state_ff <= `NSB_ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin outputs registered; strobes only between lead and trail
    wire active  = state_ff[1] | state_ff[2] | state_ff[3] |
                   state_ff[4] | state_ff[5];
    wire strobe  = state_ff[2] | state_ff[3] | state_ff[4];
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_o                 <= 32'h0000_0000;
            data_o                 <= 32'h0000_0000;
            data_oen_o             <= 1'b1;
            area_chip_select_n_o   <= 1'b1;
            bus_start_strobe_n_o   <= 1'b1;
            read_strobe_n_o        <= 1'b1;
            byte_write_strobe_n_o  <= 4'hf;
            read_write_direction_o <= 1'b1;
        end else begin
            addr_o <= {addr_ff[31:2], map_addr};
            data_o <= map_data;
            area_chip_select_n_o <= ~active;
            // One bus clock of bus start in the first access cycle
            bus_start_strobe_n_o <= ~state_ff[2];
            read_strobe_n_o <= ~(strobe & ~wr_ff);
            byte_write_strobe_n_o <= (strobe & wr_ff) ? ~map_en : 4'hf;
            read_write_direction_o <= ~(active & wr_ff);
            // Write data kept through trail cycles
            data_oen_o <= ~(active & wr_ff);
        end
    end
endmodule

/* File: tb/nsb_bus_if_chk.sv */
// Port checker for the normal-space bus sequencer
`timescale 1ns/100ps
module nsb_bus_if_chk #(
    parameter CKO_DIV = 8
) (
    // Clock, reset and configuration
    input wire        clk_i,
    input wire        rstn_i,
    input wire [3:0]  read_wait_count_i,
    input wire [2:0]  write_wait_count_i,
    input wire        external_wait_mask_i,
    input wire [1:0]  select_lead_cycles_i,
    input wire [1:0]  select_trail_cycles_i,
    // Bus pins
    input wire [31:0] data_o,
    input wire        data_oen_o,
    input wire        area_chip_select_n_o,
    input wire        bus_start_strobe_n_o,
    input wire        read_strobe_n_o,
    input wire [3:0]  byte_write_strobe_n_o,
    input wire        read_write_direction_o
);
    wire       stb_on = !read_strobe_n_o || !(&byte_write_strobe_n_o);
    reg  [7:0] gap_ff;
    reg  [7:0] on_ff;
    ////////////////////////////////////////////////////////////////////////
    // Select-only and strobe-on cycle counts, in clocks
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_ff <= 8'h00;
            on_ff  <= 8'h00;
        end else begin
            gap_ff <= (area_chip_select_n_o || stb_on) ? 8'h00 : gap_ff + 8'h01;
            on_ff  <= stb_on ? on_ff + 8'h01 : 8'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Start strobe low for one bus cycle, then released
    sequence s_start;
        !bus_start_strobe_n_o [*8] ##1 bus_start_strobe_n_o;
    endsequence
    property p_bs_len;
        $fell(bus_start_strobe_n_o) |-> s_start;
    endproperty
    a_bs_len: assert property (p_bs_len)
        else $error("start strobe width wrong");
    property p_bs_cs;
        !bus_start_strobe_n_o |-> !area_chip_select_n_o;
    endproperty
    a_bs_cs: assert property (p_bs_cs)
        else $error("start strobe outside select");
    property p_stb_cs;
        stb_on |-> !area_chip_select_n_o;
    endproperty
    a_stb_cs: assert property (p_stb_cs)
        else $error("strobe outside select");
    property p_idle_dir;
        area_chip_select_n_o |-> read_write_direction_o;
    endproperty
    a_idle_dir: assert property (p_idle_dir)
        else $error("direction low while idle");
    property p_dir;
        !(&byte_write_strobe_n_o) |-> !read_write_direction_o && read_strobe_n_o;
    endproperty
    a_dir: assert property (p_dir)
        else $error("write strobe with read direction");
    property p_lead;
        $rose(stb_on) |-> gap_ff == select_lead_cycles_i * CKO_DIV;
    endproperty
    a_lead: assert property (p_lead)
        else $error("lead cycles wrong");
    property p_trail;
        $rose(area_chip_select_n_o) |-> gap_ff == select_trail_cycles_i * CKO_DIV;
    endproperty
    a_trail: assert property (p_trail)
        else $error("trail cycles wrong");
    property p_rd_len;
        $fell(stb_on) && !$past(read_strobe_n_o) && external_wait_mask_i
            |-> on_ff == (2 + read_wait_count_i) * CKO_DIV;
    endproperty
    a_rd_len: assert property (p_rd_len)
        else $error("read strobe length wrong");
    property p_wr_len;
        $fell(stb_on) && !$past(&byte_write_strobe_n_o) && external_wait_mask_i
            |-> on_ff == (2 + write_wait_count_i) * CKO_DIV;
    endproperty
    a_wr_len: assert property (p_wr_len)
        else $error("write strobe length wrong");
    property p_wdata;
        $rose(&byte_write_strobe_n_o) |->
            (!data_oen_o && $stable(data_o)) until area_chip_select_n_o;
    endproperty
    a_wdata: assert property (p_wdata)
        else $error("write data dropped in trail");
endmodule

/* File: tb/nsb_mem.sv */
// Byte-lane memory standing on the far side of the external bus
`timescale 1ns/100ps
module nsb_mem (
    // Clock and bench controls
    input  wire        clk_i,
    input  wire        clr_i,
    input  wire [1:0]  bus_width_i,
    input  wire [2:0]  stall_i,
    // Bus pins seen from the memory
    input  wire        bus_clock_i,
    input  wire [31:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire        sel_n_i,
    input  wire        start_n_i,
    input  wire        rstb_n_i,
    input  wire [3:0]  wstb_n_i,
    output wire [31:0] q_o,
    output wire        wait_n_o
);
    reg  [7:0]  mem [0:1023];
    reg  [31:0] log_d [0:3];
    reg  [3:0]  log_we [0:3];
    reg  [2:0]  log_n, stall_ff;
    reg  [3:0]  prev_we;
    reg  [31:0] prev_d, last_q, rd_q;
    reg         prev_start, prev_bck;
    integer     l, j;
    // A physical row holds as many bytes as the bus is wide
    wire [9:0]  base = bus_width_i == 2'b11 ? {2'b00, addr_i[7:2], 2'b00}
                     : bus_width_i == 2'b10 ? {1'b0, addr_i[7:1], 2'b00}
                     : {addr_i[7:0], 2'b00};
    // Released bus shows the inverse of the last value, never a hold
    assign q_o      = (!sel_n_i && !rstb_n_i) ? rd_q : ~last_q;
    assign wait_n_o = (stall_ff == 3'd0);
    initial begin
        for (l = 0; l < 1024; l = l + 1)
            mem[l] = l[7:0] ^ 8'h5a;
        stall_ff   = 3'd0;
        log_n      = 3'd0;
        last_q     = 32'h0;
        prev_we    = 4'hf;
        prev_start = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // Storage, write log and wait generation
    always @(posedge clk_i) begin
        for (j = 0; j < 4; j = j + 1) begin
            rd_q[8*j+:8] <= mem[base + j];
            if (!wstb_n_i[j])
                mem[base + j] <= wdata_i[8*j+:8];
        end
        last_q     <= q_o;
        prev_we    <= wstb_n_i;
        prev_d     <= wdata_i;
        prev_start <= start_n_i;
        prev_bck   <= bus_clock_i;
        if (clr_i)
            log_n <= 3'd0;
        else if (&wstb_n_i && !(&prev_we) && log_n < 3'd4) begin
            log_d[log_n[1:0]]  <= prev_d;
            log_we[log_n[1:0]] <= prev_we;
            log_n              <= log_n + 3'd1;
        end
        // Changed on the rising bus edge: steady at the falling one
        if (prev_start && !start_n_i)
            stall_ff <= stall_i;
        else if (!sel_n_i && stall_ff != 3'd0 && !prev_bck && bus_clock_i)
            stall_ff <= stall_ff - 3'd1;
    end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the normal-space bus sequencer
`timescale 1ns/100ps
module testbench;
    localparam CKO_DIV = 8;
    // Design inputs
    reg         clk_i, rstn_i, endian_select_pin_i, external_wait_mask_i;
    reg         req_valid_i, req_write_i, clr_log;
    reg  [1:0]  bus_width_i, req_size_i;
    reg  [1:0]  select_lead_cycles_i, select_trail_cycles_i;
    reg  [3:0]  read_wait_count_i;
    reg  [2:0]  write_wait_count_i;
    reg  [31:0] req_addr_i, req_wdata_i;
    // Design outputs and bus wires
    wire        req_ready_o, rsp_valid_o, big_endian_o, bus_clock_output_o;
    wire        data_oen_o, area_chip_select_n_o, bus_start_strobe_n_o;
    wire        read_strobe_n_o, read_write_direction_o, ext_wait_n_i;
    wire [3:0]  byte_write_strobe_n_o;
    wire [31:0] rsp_rdata_o, addr_o, data_o, data_i, mem_q;
    integer     error_cnt, checks_done, e, i, p, l, k, w;
    reg  [31:0] v, ve, rd_q;
    reg  [7:0]  b;
    reg  [2:0]  lane;
    // Data wire: design drives while its enable is low
    assign data_i = data_oen_o ? mem_q : data_o;
    // Every design port has a bench signal of its name
    nsb_bus_if #(.CKO_DIV(CKO_DIV)) u_nsb_bus_if (.*);
    nsb_mem u_nsb_mem (
        .clk_i(clk_i), .clr_i(clr_log), .bus_width_i(bus_width_i),
        .stall_i(3'd2), .bus_clock_i(bus_clock_output_o), .addr_i(addr_o),
        .wdata_i(data_o), .sel_n_i(area_chip_select_n_o),
        .start_n_i(bus_start_strobe_n_o), .rstb_n_i(read_strobe_n_o),
        .wstb_n_i(byte_write_strobe_n_o), .q_o(mem_q),
        .wait_n_o(ext_wait_n_i));
    ////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: saw %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask
    // One request, held until taken, then wait for its answer
    task access(input wr, input [1:0] sz, input [31:0] a, input [31:0] d);
        integer n;
        begin
            req_valid_i <= 1'b1;
            req_write_i <= wr;
            req_size_i  <= sz;
            req_addr_i  <= a;
            req_wdata_i <= d;
            clr_log     <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (req_ready_o !== 1'b1 && n < 400);
            req_valid_i <= 1'b0;
            clr_log     <= 1'b0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (rsp_valid_o !== 1'b1 && n < 3000);
            rd_q = rsp_rdata_o;
            if (n >= 3000)
                error_cnt = error_cnt + 1;
        end
    endtask
    // Every logged piece of a longword write
    task check_long;
        begin
            check(u_nsb_mem.log_n, 4 / w);
            for (p = 0; p < 4 / w; p = p + 1) begin
                check(u_nsb_mem.log_we[p], {28'h0, 4'hf << w});
                for (l = 0; l < w; l = l + 1) begin
                    k = p * w + (e ? l : w - 1 - l);
                    b = v[8*(e ? k : 3 - k)+:8];
                    check(u_nsb_mem.log_d[p][8*l+:8], b);
                end
            end
        end
    endtask
    task summarize;
        begin
            if (error_cnt == 0 && checks_done > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Watchdog well past the expected three thousand or so clocks
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt = error_cnt + 1;
        summarize;
    end
    initial begin
        error_cnt = 0;
        checks_done = 0;
        {rstn_i, endian_select_pin_i, req_valid_i, req_write_i} = 4'h0;
        {clr_log, external_wait_mask_i, req_size_i} = 4'h0;
        {bus_width_i, select_lead_cycles_i, select_trail_cycles_i} = 6'h3f;
        {read_wait_count_i, write_wait_count_i} = 7'h0;
        {req_addr_i, req_wdata_i} = 64'h0;
        // Second pass resets mid-run with the strap flipped
        for (e = 0; e < 2; e = e + 1) begin
            rstn_i              <= 1'b0;
            endian_select_pin_i <= e[0];
            repeat (2) @(posedge clk_i);
            rstn_i <= 1'b1;
            repeat (40) @(posedge clk_i);
            check(big_endian_o, e == 0);
            check(read_write_direction_o, 1);
            for (i = 0; i < 3; i = i + 1) begin
                w = 4 >> i;
                bus_width_i           <= 2'd3 - i[1:0];
                read_wait_count_i     <= i[3:0];
                write_wait_count_i    <= i[2:0];
                select_lead_cycles_i  <= i[1:0];
                select_trail_cycles_i <= 2'd2 - i[1:0];
                external_wait_mask_i  <= (i != 1);
                v = 32'h8c4d2e1f;
                access(1'b1, 2'b10, 32'h10, v);
                check_long;
                lane = e ? 1 % w : w - 1 - 1 % w;
                access(1'b1, 2'b00, 32'h11, 32'ha7);
                check(u_nsb_mem.log_we[0], {28'h0, ~(4'h1 << lane)});
                check(u_nsb_mem.log_d[0][8*lane+:8], 8'ha7);
                ve = v;
                ve[(e ? 8 : 16)+:8] = 8'ha7;
                access(1'b0, 2'b10, 32'h10, 32'h0);
                check(rd_q, ve);
                access(1'b0, 2'b01, 32'h12, 32'h0);
                check(rd_q, e ? ve[31:16] : ve[15:0]);
                access(1'b0, 2'b00, 32'h13, 32'h0);
                check(rd_q, e ? ve[31:24] : ve[7:0]);
            end
        end
        summarize;
    end
endmodule

bind nsb_bus_if nsb_bus_if_chk #(.CKO_DIV(CKO_DIV)) u_nsb_bus_if_chk (.*);
